//--- common/sio_pkg.sv
// constants and carrier types of the serial port
// assumes one core clock domain for control ports
package sio_pkg;

    // data width and bit positions
    localparam int          DATA_W      = 8;
    localparam logic [2:0]  BIT_LAST    = 3'h7;
    localparam logic [2:0]  BIT_ZERO    = 3'h0;

    // bit order select encodings
    localparam logic        ORDER_MSB   = 1'b0;
    localparam logic        ORDER_LSB   = 1'b1;

    // transfer modes (11 idles the port)
    localparam logic [1:0]  MODE_TX     = 2'b00;
    localparam logic [1:0]  MODE_RX     = 2'b01;
    localparam logic [1:0]  MODE_TRX    = 2'b10;

    // clock select codes and divider exponents
    localparam logic [2:0]  CLK_EXT     = 3'h7;
    localparam logic [2:0]  CLK_SLOW    = 3'h0;
    localparam logic [3:0]  DIV_EXP_SLOW = 4'hC;
    localparam logic [3:0]  DIV_EXP_BASE = 4'h9;
    localparam int          DIV_CNT_W   = 12;

    // reset values
    localparam logic [7:0]  RX_BUF_RST  = 8'h00;
    localparam logic        PIN_IDLE    = 1'b1;

    // two-entry transmit buffer depth
    localparam int          TX_DEPTH    = 2;

    // control settings written by software
    typedef struct packed {
        logic       bitOrderSelect;     // 0 msb first, 1 lsb first
        logic [1:0] transferModeField;  // tx, rx, tx/rx
        logic [2:0] clockSelect;        // 111 external, else internal rate
    } serial_control_t;

    // status flags read by software
    typedef struct packed {
        logic transferActiveFlag;
        logic shiftActiveFlag;
        logic txBufferEmptyFlag;
        logic rxBufferFullFlag;
        logic txUnderrunFlag;
        logic rxOverrunFlag;
    } serial_status_t;

endpackage

//--- rtl/sio_tx_fifo.sv
// two-entry fifo, valid/ready both sides
// single clock; flush empties it at once
`timescale 1ns/1ps
`default_nettype none

module sio_tx_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2
) (
    input  wire logic             clk,       // core clock
    input  wire logic             rst,       // async reset, active high
    input  wire logic             flush,     // drop all entries
    input  wire logic             inValid,   // writer offers a word
    output logic                  inReady,   // room for a word
    input  wire logic [WIDTH-1:0] inData,    // word written
    output logic                  outValid,  // a word is held
    input  wire logic             outReady,  // reader takes the word
    output logic      [WIDTH-1:0] outData    // oldest word
);

    localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CNT_W = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] store [DEPTH];
    logic [PTR_W-1:0] wrPtr_reg, wrPtr_next, rdPtr_reg, rdPtr_next;
    logic [CNT_W-1:0] count_reg, count_next;
    logic             push, pop;

    // handshake and fill level
    assign inReady  = (count_reg != CNT_W'(DEPTH));
    assign outValid = (count_reg != '0);
    assign outData  = store[rdPtr_reg];
    assign push     = inValid && inReady && !flush;
    assign pop      = outValid && outReady && !flush;

    // pointer arithmetic with wrap
    function automatic logic [PTR_W-1:0] bump(input logic [PTR_W-1:0] p);
        bump = (p == PTR_W'(DEPTH - 1)) ? '0 : p + PTR_W'(1);
    endfunction

    // next pointers and count
    always_comb begin
        wrPtr_next = push ? bump(wrPtr_reg) : wrPtr_reg;
        rdPtr_next = pop ? bump(rdPtr_reg) : rdPtr_reg;
        count_next = count_reg + CNT_W'(push) - CNT_W'(pop);
        if (flush) begin
            wrPtr_next = '0;
            rdPtr_next = '0;
            count_next = '0;
        end
    end

    // pointer registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wrPtr_reg <= '0;
            rdPtr_reg <= '0;
            count_reg <= '0;
        end else begin
            wrPtr_reg <= wrPtr_next;
            rdPtr_reg <= rdPtr_next;
            count_reg <= count_next;
        end
    end

    // storage, written on push
    always_ff @(posedge clk) begin
        if (push) begin
            store[wrPtr_reg] <= inData;
        end
    end

endmodule

`default_nettype wire

//--- rtl/sync_serial_tx_rx_port.sv
// eight-bit synchronous serial port: shifter, clocking, flags, buffers
// assumes cpu ports on clk; serial pins asynchronous
//
// Function
// [R1] order 0 bit 7 first, 1 bit 0 first
// [R2] mode 00 transmit, 01 receive
// [R3] mode 10 transmit and receive
// [R4] select 111 external clock, else internal out
// [R5] buffer write clears empty flag
// [R6] active sets on a fall after start
// [R7] bits leave on clock falls
// [R8] bits sampled on clock rises
// [R9] shift-active first to eighth fall
// [R10] empty sets at rise after load, event next fall; code raises the event in mode 00 only
// [R11] internal transmit waits for data
// [R12] internal clock starts within a cycle
// [R13] external loads on first fall
// [R14] internal clock parks until serviced
// [R15] word written mid-byte follows at once
// [R16] peer refills transmit data in time
// [R17] empty at shift start: underrun, event
// [R18] cleared start ends after byte, output high
// [R19] start cleared before next byte
// [R20] force stop clears start, status, buffers
// [R21] eight bits fill receive buffer, event
// [R22] receive read clears full
// [R23] overrun sets flag, event, ignores data
// [R24] overrun: first read old byte, then shifter
`timescale 1ns/1ps
`default_nettype none

module sync_serial_tx_rx_port
    import sio_pkg::*;
(
    input  wire logic                     clk, // core clock
    input  wire logic                     rst, // async reset
    input  wire sio_pkg::serial_control_t ctrl, // settings
    input  wire logic                     startWrite, // load start bit
    input  wire logic                     startValue, // start bit value
    input  wire logic                     forceStop, // halt and clear
    input  wire logic                     txWrite, // write word
    input  wire logic [7:0]               txData, // word
    output logic                          txWriteReady, // room
    input  wire logic                     rxRead, // read word
    output logic      [7:0]               rxData, // receive buffer
    input  wire logic                     txErrClear, // clear underrun
    input  wire logic                     rxErrClear, // clear overrun
    output logic                          transferStartBit, // start bit
    output sio_pkg::serial_status_t       status, // flags
    output logic                          serialInterrupt, // event pulse
    input  wire logic                     sckIn, // clock pin in
    output logic                          sckOut, // clock pin out
    output logic                          sckOe, // clock pin enable
    output logic                          serialOutputPin, // data out
    input  wire logic                     serialInputPin // data in
);

    typedef enum logic [1:0] {PH_IDLE, PH_WAIT, PH_SHIFT} phase_t;

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers and edge detection

    logic sckMeta_reg, sckSync_reg, sckPrev_reg, siMeta_reg, siSync_reg;

    // two flops per pin, previous level for edges
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sckMeta_reg <= PIN_IDLE;
            sckSync_reg <= PIN_IDLE;
            sckPrev_reg <= PIN_IDLE;
            siMeta_reg  <= PIN_IDLE;
            siSync_reg  <= PIN_IDLE;
        end else begin
            sckMeta_reg <= sckIn;
            sckSync_reg <= sckMeta_reg;
            sckPrev_reg <= sckSync_reg;
            siMeta_reg  <= serialInputPin;
            siSync_reg  <= siMeta_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state and transmit buffer

    phase_t      phase_reg, phase_next;
    logic [DIV_CNT_W-1:0] divCnt_reg, divCnt_next;
    logic        sckInt_reg, sckInt_next;
    logic [2:0]  fallCnt_reg, fallCnt_next, riseCnt_reg, riseCnt_next;
    logic [7:0]  shift_reg, shift_next, rxBuf_reg, rxBuf_next, shadow_reg, shadow_next;
    logic        start_reg, start_next, sef_reg, sef_next, txEmpty_reg, txEmpty_next;
    logic        rxFull_reg, rxFull_next, tx_underrun_flag_reg, tx_underrun_flag_next, rx_overrun_flag_reg, rx_overrun_flag_next;
    logic        so_reg, so_next, irq_reg, irq_next, irqPend_reg, irqPend_next;
    logic        loaded_reg, loaded_next;
    logic        fifoValid, fifoPop, fifoIn;
    logic [7:0]  fifoData;

    // two-entry write buffer; full stalls writer
    assign fifoIn = txWrite && txWriteReady;
    sio_tx_fifo #(
        .WIDTH (DATA_W),
        .DEPTH (TX_DEPTH)
    ) txFifo (
        .clk      (clk),
        .rst      (rst),
        .flush    (forceStop),
        .inValid  (txWrite),
        .inReady  (txWriteReady),
        .inData   (txData),
        .outValid (fifoValid),
        .outReady (fifoPop),
        .outData  (fifoData)
    );

    // first bit out for the order
    function automatic logic leadBit(input logic [7:0] v, input logic order);
        leadBit = (order == ORDER_LSB) ? v[BIT_ZERO] : v[BIT_LAST];
    endfunction

    // internal clock half period in clk cycles
    function automatic logic [DIV_CNT_W-1:0] halfDiv(input logic [2:0] sel);
        logic [3:0] e;
        e = (sel == CLK_SLOW) ? DIV_EXP_SLOW : DIV_EXP_BASE - {1'b0, sel};
        halfDiv = DIV_CNT_W'(1) << (e - 4'h1);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // next state of shifter, clock, flags

    logic isExt, useTx, useRx, modeOk, bufOk, fall, rise, tgl, atBoundary;

    always_comb begin
        // [R4] clock source
        isExt  = (ctrl.clockSelect == CLK_EXT);
        // [R2] [R3] mode decode
        useTx  = (ctrl.transferModeField == MODE_TX) || (ctrl.transferModeField == MODE_TRX);
        useRx  = (ctrl.transferModeField == MODE_RX) || (ctrl.transferModeField == MODE_TRX);
        modeOk = useTx || useRx;
        // [R11] [R14] auto-wait
        bufOk  = (!useTx || fifoValid) && (!useRx || !rxFull_reg);
        atBoundary = (phase_reg != PH_SHIFT);

        phase_next   = phase_reg;
        divCnt_next  = divCnt_reg;
        sckInt_next  = sckInt_reg;
        fallCnt_next = fallCnt_reg;
        riseCnt_next = riseCnt_reg;
        shift_next   = shift_reg;
        rxBuf_next   = rxBuf_reg;
        shadow_next  = shadow_reg;
        start_next   = startWrite ? startValue : start_reg;
        sef_next     = sef_reg;
        txEmpty_next = txEmpty_reg;
        rxFull_next  = rxFull_reg;
        tx_underrun_flag_next   = tx_underrun_flag_reg && !txErrClear;
        rx_overrun_flag_next   = rx_overrun_flag_reg;
        so_next      = so_reg;
        irq_next     = 1'b0;
        irqPend_next = irqPend_reg;
        loaded_next  = loaded_reg;
        fifoPop      = 1'b0;
        tgl          = 1'b0;

        // [R12] [R14] clock runs in a byte or when ready
        if (!isExt && modeOk && (!atBoundary || (start_reg && bufOk))) begin
            if (divCnt_reg == halfDiv(ctrl.clockSelect) - DIV_CNT_W'(1)) begin
                divCnt_next = '0;
                tgl         = 1'b1;
                sckInt_next = !sckInt_reg;
            end else begin
                divCnt_next = divCnt_reg + DIV_CNT_W'(1);
            end
        end else begin
            divCnt_next = '0;
            sckInt_next = PIN_IDLE;
        end
        fall = isExt ? (sckPrev_reg && !sckSync_reg) : (tgl && sckInt_reg);
        rise = isExt ? (!sckPrev_reg && sckSync_reg) : (tgl && !sckInt_reg);

        // [R5] write clears empty flag
        if (fifoIn) begin
            txEmpty_next = 1'b0;
        end

        if (fall && modeOk) begin
            if (atBoundary && start_reg) begin
                // [R6] [R9] first fall: active, shift-active
                phase_next   = PH_SHIFT;
                sef_next     = 1'b1;
                fallCnt_next = BIT_ZERO;
                riseCnt_next = BIT_ZERO;
                if (useTx && fifoValid) begin
                    // [R13] [R12] load shifter
                    fifoPop     = 1'b1;
                    loaded_next = 1'b1;
                    shift_next  = fifoData;
                    // [R7] [R1] first bit out
                    so_next     = tx_underrun_flag_reg ? PIN_IDLE : leadBit(fifoData, ctrl.bitOrderSelect);
                end else if (useTx) begin
                    // [R17] nothing to send: underrun
                    tx_underrun_flag_next = 1'b1;
                    so_next    = PIN_IDLE;
                end
            end else if (!atBoundary) begin
                fallCnt_next = fallCnt_reg + 3'h1;
                // [R9] eighth fall drops shift-active
                if (fallCnt_reg == BIT_LAST - 3'h1) begin
                    sef_next = 1'b0;
                end
                // [R7] next bit out
                if (useTx && !tx_underrun_flag_reg) begin
                    so_next = leadBit(shift_reg, ctrl.bitOrderSelect);
                end
                // [R10] empty event on the following fall
                if (irqPend_reg) begin
                    irqPend_next = 1'b0;
                    irq_next     = 1'b1;
                end
            end
        end

        if (rise && modeOk && !atBoundary) begin
            // [R8] [R1] sample in set order
            shift_next = (ctrl.bitOrderSelect == ORDER_LSB)
                       ? {siSync_reg, shift_reg[7:1]} : {shift_reg[6:0], siSync_reg};
            riseCnt_next = riseCnt_reg + 3'h1;
            // [R10] empty sets on rise after load
            if (loaded_reg) begin
                loaded_next = 1'b0;
                if (!fifoValid && !fifoIn) begin
                    txEmpty_next = 1'b1;
                    irqPend_next = (ctrl.transferModeField == MODE_TX);
                end
            end
            if (riseCnt_reg == BIT_LAST) begin
                // [R18] byte done; ends without start
                phase_next = start_reg ? PH_WAIT : PH_IDLE;
                if (!start_reg || tx_underrun_flag_reg) begin
                    so_next = PIN_IDLE;
                end
                // [R17] underrun reported at byte end
                if (tx_underrun_flag_reg || (useTx && !loaded_reg && tx_underrun_flag_next)) begin
                    irq_next = 1'b1;
                end
                if (useRx && !rx_overrun_flag_reg) begin
                    if (rxFull_reg && !rxRead) begin
                        // [R23] overrun: keep buffer, hold shifter copy
                        rx_overrun_flag_next  = 1'b1;
                        shadow_next = shift_next;
                        irq_next    = 1'b1;
                    end else begin
                        // [R21] store byte, set full, interrupt
                        rxBuf_next  = shift_next;
                        rxFull_next = 1'b1;
                        irq_next    = 1'b1;
                    end
                end
            end
        end

        // [R22] [R24] read clears full, or shows shifter copy
        if (rxRead && !(rise && riseCnt_reg == BIT_LAST && useRx && !rx_overrun_flag_reg)) begin
            if (rx_overrun_flag_reg) begin
                rxBuf_next = shadow_reg;
            end else begin
                rxFull_next = 1'b0;
            end
        end
        // clears lose to a set
        if (rxErrClear && rx_overrun_flag_reg && rx_overrun_flag_next) begin
            rx_overrun_flag_next  = 1'b0;
            rxFull_next = 1'b0;
        end
        // [R18] cleared start ends a paused transfer
        if (phase_reg == PH_WAIT && !start_reg) begin
            phase_next = PH_IDLE;
        end

        // [R18] idle line high
        if (phase_next == PH_IDLE) begin
            so_next = PIN_IDLE;
        end

        // [R20] force stop clears all but the shifter and its copy
        if (forceStop) begin
            phase_next   = PH_IDLE;
            divCnt_next  = '0;
            sckInt_next  = PIN_IDLE;
            fallCnt_next = BIT_ZERO;
            riseCnt_next = BIT_ZERO;
            start_next   = 1'b0;
            sef_next     = 1'b0;
            txEmpty_next = 1'b1;
            rxFull_next  = 1'b0;
            tx_underrun_flag_next   = 1'b0;
            rx_overrun_flag_next   = 1'b0;
            rxBuf_next   = RX_BUF_RST;
            so_next      = PIN_IDLE;
            irq_next     = 1'b0;
            irqPend_next = 1'b0;
            loaded_next  = 1'b0;
            fifoPop      = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state registers

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            phase_reg   <= PH_IDLE;
            divCnt_reg  <= '0;
            sckInt_reg  <= PIN_IDLE;
            fallCnt_reg <= BIT_ZERO;
            riseCnt_reg <= BIT_ZERO;
            shift_reg   <= RX_BUF_RST;
            rxBuf_reg   <= RX_BUF_RST;
            shadow_reg  <= RX_BUF_RST;
            start_reg   <= 1'b0;
            sef_reg     <= 1'b0;
            txEmpty_reg <= 1'b1;
            rxFull_reg  <= 1'b0;
            tx_underrun_flag_reg   <= 1'b0;
            rx_overrun_flag_reg   <= 1'b0;
            so_reg      <= PIN_IDLE;
            irq_reg     <= 1'b0;
            irqPend_reg <= 1'b0;
            loaded_reg  <= 1'b0;
        end else begin
            phase_reg   <= phase_next;
            divCnt_reg  <= divCnt_next;
            sckInt_reg  <= sckInt_next;
            fallCnt_reg <= fallCnt_next;
            riseCnt_reg <= riseCnt_next;
            shift_reg   <= shift_next;
            rxBuf_reg   <= rxBuf_next;
            shadow_reg  <= shadow_next;
            start_reg   <= start_next;
            sef_reg     <= sef_next;
            txEmpty_reg <= txEmpty_next;
            rxFull_reg  <= rxFull_next;
            tx_underrun_flag_reg   <= tx_underrun_flag_next;
            rx_overrun_flag_reg   <= rx_overrun_flag_next;
            so_reg      <= so_next;
            irq_reg     <= irq_next;
            irqPend_reg <= irqPend_next;
            loaded_reg  <= loaded_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    // [R4] pin driven with internal clock
    assign sckOe            = (ctrl.clockSelect != CLK_EXT);
    assign sckOut           = sckInt_reg;
    assign serialOutputPin  = so_reg;
    assign rxData           = rxBuf_reg;
    assign transferStartBit = start_reg;
    assign serialInterrupt  = irq_reg;
    assign status.transferActiveFlag = (phase_reg != PH_IDLE);
    assign status.shiftActiveFlag    = sef_reg;
    assign status.txBufferEmptyFlag  = txEmpty_reg;
    assign status.rxBufferFullFlag   = rxFull_reg;
    assign status.txUnderrunFlag     = tx_underrun_flag_reg;
    assign status.rxOverrunFlag      = rx_overrun_flag_reg;

endmodule

`default_nettype wire

//--- tb/serial_peer_model.sv
// serial peer: clocks frames, sends, captures
// assumes the clock pin level comes back as lineClk
`timescale 1ns/1ps
`default_nettype none
module serial_peer_model (
    input  wire logic       frameGo,  // pulse: clock one byte
    input  wire logic       lsbFirst, // 1: bit 0 first
    input  wire logic [7:0] peerByte, // byte for the port
    input  wire logic       lineClk,  // clock pin level
    input  wire logic       portOut,  // port data out
    output logic            peerClk,  // clock from the peer
    output logic            peerData, // data to the port
    output logic [7:0]      peerGot   // last byte seen
);
    logic [7:0] sh;
    int         n;
    initial begin
        peerClk = 1'b1;
        peerData = 1'b0;
        peerGot = 8'h00;
        sh = 8'h00;
        n = 0;
    end
    // 16 ns per level; still between frames
    always @(posedge frameGo) begin
        sh = peerByte;
        repeat (8) begin
            peerClk = 1'b0;
            #16 peerClk = 1'b1;
            #16;
        end
    end
    // next bit after each fall
    always @(negedge lineClk) begin
        #4 peerData = lsbFirst ? sh[0] : sh[7];
        sh = lsbFirst ? sh >> 1 : sh << 1;
    end
    // capture late in high level; line inverts after a byte
    always @(posedge lineClk) begin
        #12 peerGot = lsbFirst ? {portOut, peerGot[7:1]} : {peerGot[6:0], portOut};
        n = n + 1;
        if (n % 8 == 0) peerData = ~peerData;
    end
endmodule
`default_nettype wire

//--- tb/serial_port_checker.sv
// checks on the port's flags and pins
// assumes a bind onto the port top; one clock domain
`timescale 1ns/1ps
`default_nettype none
module serial_port_checker
    import sio_pkg::*;
(
    input wire logic                     clk,              // core clock
    input wire logic                     rst,              // reset
    input wire sio_pkg::serial_control_t ctrl,             // settings
    input wire logic                     forceStop,        // halt pulse
    input wire logic                     txWrite,          // write pulse
    input wire logic                     txWriteReady,     // room
    input wire logic                     rxRead,           // read pulse
    input wire logic [7:0]               rxData,           // receive buffer
    input wire logic                     transferStartBit, // start bit
    input wire sio_pkg::serial_status_t  status,           // flags
    input wire logic                     serialInterrupt,  // event pulse
    input wire logic                     sckOut,           // clock out
    input wire logic                     sckOe,            // clock enable
    input wire logic                     serialOutputPin   // data out
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence wr_taken; txWrite && txWriteReady; endsequence
    sequence stop_req; forceStop; endsequence
    ////////////////////////////////////////////////////////////////////////////
    wr_empty_a: assert property (wr_taken |=> !status.txBufferEmptyFlag)
        else $error("empty flag kept after write");
    rd_full_a: assert property (rxRead && !status.rxOverrunFlag |=>
        !status.rxBufferFullFlag || serialInterrupt) else $error("full kept after read");
    stop_clear_a: assert property (stop_req |=> !transferStartBit &&
        status == 6'h08 && rxData == 8'h00) else $error("force stop left state");
    pin_drive_a: assert property (sckOe == (ctrl.clockSelect != CLK_EXT))
        else $error("clock enable wrong");
    end_park_a: assert property ($fell(status.transferActiveFlag) && !$past(forceStop)
        |-> serialOutputPin) else $error("data out not high at stop");
    sck_park_a: assert property (!transferStartBit && !status.transferActiveFlag
        |-> sckOut) else $error("clock not parked");
    shift_in_a: assert property (status.shiftActiveFlag |-> status.transferActiveFlag)
        else $error("shift outside transfer");
    under_irq_a: assert property ($rose(status.txUnderrunFlag) |-> ##[1:100] serialInterrupt)
        else $error("no event after underrun");
    full_irq_a: assert property ($rose(status.rxBufferFullFlag) |-> serialInterrupt)
        else $error("no event with full");
endmodule
`default_nettype wire

//--- tb/tb.sv
// self-checking bench of the synchronous serial port
// assumes package, design, checker, peer compile first
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin tests_run++; if ((a) !== (e)) begin errors++; \
    $display("mismatch %s exp %0h got %0h", n, e, a); end end
module tb;
    import sio_pkg::*;
    logic            clk = 1'b0;
    logic            rst = 1'b1;
    serial_control_t ctrl;
    logic            startWrite, startValue, forceStop, txWrite, rxRead;
    logic            txErrClear, rxErrClear, frameGo, sckPin;
    logic [7:0]      txData, rxData, peerByte, peerGot;
    logic            txWriteReady, transferStartBit, serialInterrupt;
    logic            sckOut, sckOe, serialOutputPin, peerClk, peerData;
    serial_status_t  status;
    int              errors = 0, tests_run = 0, cycles = 0;
    always #2 clk = ~clk;
    assign sckPin = sckOe ? sckOut : peerClk;
    sync_serial_tx_rx_port dut_u (.clk, .rst, .ctrl, .startWrite, .startValue, .forceStop,
        .txWrite, .txData, .txWriteReady, .rxRead, .rxData, .txErrClear, .rxErrClear,
        .transferStartBit, .status, .serialInterrupt, .sckIn(sckPin), .sckOut, .sckOe,
        .serialOutputPin, .serialInputPin(peerData));
    serial_peer_model peer_u (.frameGo, .lsbFirst(ctrl.bitOrderSelect), .peerByte,
        .lineClk(sckPin), .portOut(serialOutputPin), .peerClk, .peerData, .peerGot);
    ////////////////////////////////////////////////////////////////////////////
    task automatic pulse(ref logic s);
        s = 1'b1;
        @(negedge clk);
        s = 1'b0;
        @(negedge clk);
    endtask
    task automatic wt(input int k);
        repeat (k) @(negedge clk);
    endtask
    task automatic put(input logic [7:0] d);
        txData = d;
        pulse(txWrite);
    endtask
    task automatic start(input logic v);
        startValue = v;
        pulse(startWrite);
    endtask
    task automatic frame(input logic [7:0] d);
        peerByte = d;
        frameGo = 1'b1;
        @(negedge clk);
        frameGo = 1'b0;
        wt(80);
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic ext_trx;
        ctrl = '{ORDER_MSB, MODE_TRX, CLK_EXT};
        put(8'h81);
        `CHK("txempty", 1'b0, status.txBufferEmptyFlag)
        start(1'b1);
        frame(8'h3C);
        `CHK("sent", 8'h81, peerGot)
        `CHK("rxdata", 8'h3C, rxData)
        `CHK("active", 1'b1, status.transferActiveFlag)
        `CHK("txempty", 1'b1, status.txBufferEmptyFlag)
        pulse(rxRead);
        `CHK("rxfull", 1'b0, status.rxBufferFullFlag)
        put(8'h5A); // refill before the next byte
        frame(8'hA5);
        `CHK("sent", 8'h5A, peerGot)
        `CHK("rxdata", 8'hA5, rxData)
        pulse(forceStop);
        `CHK("status", 6'h08, status)
        `CHK("rxdata", 8'h00, rxData)
        $display("test ext_trx done");
    endtask
    task automatic ext_rx;
        ctrl = '{ORDER_LSB, MODE_RX, CLK_EXT};
        start(1'b1);
        frame(8'h01);
        `CHK("rxdata", 8'h01, rxData)
        frame(8'h80);
        `CHK("overrun", 1'b1, status.rxOverrunFlag)
        frame(8'h33);
        `CHK("rxdata", 8'h01, rxData)
        pulse(rxRead);
        `CHK("rxdata", 8'h80, rxData)
        pulse(rxErrClear);
        `CHK("overrun", 1'b0, status.rxOverrunFlag)
        pulse(forceStop);
        `CHK("start", 1'b0, transferStartBit)
        $display("test ext_rx done");
    endtask
    task automatic ext_under;
        ctrl = '{ORDER_MSB, MODE_TX, CLK_EXT};
        start(1'b1);
        frame(8'h00);
        `CHK("underrun", 1'b1, status.txUnderrunFlag)
        `CHK("sent", 8'hFF, peerGot)
        pulse(txErrClear);
        `CHK("underrun", 1'b0, status.txUnderrunFlag)
        pulse(forceStop);
        $display("test ext_under done");
    endtask
    task automatic int_tx;
        ctrl = '{ORDER_MSB, MODE_TX, 3'h6};
        start(1'b1);
        wt(40);
        `CHK("active", 1'b0, status.transferActiveFlag)
        put(8'hC3);
        put(8'h3C); // second word follows at once
        wt(6);
        `CHK("active", 1'b1, status.transferActiveFlag)
        wt(200);
        `CHK("sent", 8'h3C, peerGot)
        `CHK("parked", 1'b1, sckOut)
        put(8'h96);
        wt(100);
        `CHK("sent", 8'h96, peerGot)
        start(1'b0);
        wt(20);
        `CHK("active", 1'b0, status.transferActiveFlag)
        `CHK("dataout", 1'b1, serialOutputPin)
        $display("test int_tx done");
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // hang guard
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            errors++;
            print_verdict();
        end
    end
    initial begin
        ctrl = '{ORDER_MSB, MODE_TX, CLK_EXT};
        {startWrite, startValue, forceStop, txWrite, rxRead, txErrClear, rxErrClear} = '0;
        {frameGo, txData, peerByte} = '0;
        wt(20);
        rst = 1'b0;
        @(negedge clk);
        `CHK("status", 6'h08, status)
        ext_trx();
        ext_rx();
        ext_under();
        int_tx();
        print_verdict();
    end
endmodule
bind sync_serial_tx_rx_port serial_port_checker chk_u (.clk, .rst, .ctrl, .forceStop,
    .txWrite, .txWriteReady, .rxRead, .rxData, .transferStartBit, .status,
    .serialInterrupt, .sckOut, .sckOe, .serialOutputPin);
`default_nettype wire
